// [hw/celp_encoder.sv]
// speech frame encoder: sample intake, frame sequencing, bit emission
`timescale 1ns/1ps
`default_nettype none
`include "celp_defines.svh"
module celp_encoder
#(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic smp_stb_i,
    input wire logic [15:0] smp_i,
    input wire celp_pkg::celp_fmt_e fmt_i,
    input wire celp_pkg::celp_mode_e mode_i,
    output logic bit_o,
    output logic bit_vld_o,
    output logic frame_start_o,
    output logic frame_end_o,
    output logic [2:0] frame_mode_o,
    output logic [7:0] sub_idx_o,
    output logic [15:0] dec_smp_o,
    output logic overrun_o
);
    import celp_pkg::*;

    // ------------------------------------------------------------
    // g711 expansion
    // ------------------------------------------------------------
    function automatic logic [12:0] alaw_exp(input logic [7:0] c);
        logic [7:0] x;
        logic [12:0] m;
        x = c ^ 8'h55;
        if (x[6:4] == 3'h0) m = {5'h00, x[3:0], 4'h8} >> 3;
        else m = 13'(16'((({12'h001, x[3:0]} << 4) | 16'h0008) <<
                 (x[6:4] - 3'h1)) >> 3);
        return x[7] ? m : 13'(-m);
    endfunction : alaw_exp
    function automatic logic [12:0] ulaw_exp(input logic [7:0] c);
        logic [7:0] x;
        logic [15:0] m;
        x = ~c;
        m = 16'((({12'h000, x[3:0]} << 3) + 16'(`CE_MU_BIAS)) << x[6:4]);
        m = m - 16'(`CE_MU_BIAS);
        return x[7] ? 13'(-(m >> 3)) : 13'(m >> 3);
    endfunction : ulaw_exp

    // ------------------------------------------------------------
    // input synchronisers and sample conversion
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] stb_sync;
        logic [15:0] smp_s1;
        logic [15:0] smp_s2;
        logic [15:0] lin;
        logic lin_vld;
        celp_state_e st;
        logic [7:0] cnt;
        logic [7:0] sub;
        logic [1:0] lp_pass;
        celp_mode_e fmode;
        logic [15:0] g1;
        logic [15:0] ol_lag;
        logic [7:0] bitcnt;
        logic [7:0] fbits;
        logic [15:0] sh;
        logic [3:0] shcnt;
        logic [31:0] acc;
        logic [15:0] exc;
        logic bit_q;
        logic bit_vld;
        logic fs;
        logic fe;
        logic [15:0] dec;
        logic ovr;
    } celp_enc_s;
    celp_enc_s s_r, s_nxt;
    logic [15:0] fifo_dout;
    logic fifo_ovld, fifo_ordy, fifo_irdy;
    logic [15:0] lpc [`CE_LP_ORDER];
    logic [15:0] mem_syn [`CE_LP_ORDER];
    logic [15:0] frame_buf [`CE_FRAME_LEN];
    logic [7:0] wr_idx_r;
    logic frame_full;
    // eight modes mapped to frame bit totals
    function automatic logic [7:0] frame_bits(input celp_mode_e m);
        case (m)
            CE_M475: return 8'd95;
            CE_M515: return 8'd103;
            CE_M590: return 8'd118;
            CE_M670: return 8'd134;
            CE_M740: return 8'd148;
            CE_M795: return 8'd159;
            CE_M102: return 8'd204;
            default: return 8'd244;
        endcase
    endfunction : frame_bits
    function automatic logic [15:0] to_word(input logic [12:0] v);
        return {v, `CE_LSB_PAD'(0)};
    endfunction : to_word
    // sample strobe edge, read from second and third flops
    wire stb_rise = s_r.stb_sync[1] & ~s_r.stb_sync[2];

    celp_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .in_valid_i(s_r.lin_vld),
        .in_ready_o(fifo_irdy),
        .in_data_i(s_r.lin),
        .out_valid_o(fifo_ovld),
        .out_ready_i(fifo_ordy),
        .out_data_o(fifo_dout)
    );
    // fifo drains only while frame buffer is being filled
    assign frame_full = (wr_idx_r == 8'(`CE_FRAME_LEN));
    assign fifo_ordy = ~frame_full;

    // ------------------------------------------------------------
    // frame buffer and filter memories
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_idx_r <= 8'h00;
        end else if (fifo_ovld & fifo_ordy) begin
            wr_idx_r <= wr_idx_r + 8'h01;
        end else if (frame_full && s_r.st == CE_S_IDLE) begin
            wr_idx_r <= 8'h00;
        end
    end
    always_ff @(posedge mclk_i) begin
        if (fifo_ovld & fifo_ordy) frame_buf[wr_idx_r] <= fifo_dout;
    end

    // order-ten all-pole state; updated with excitation
    genvar gi;
    generate
        for (gi = 0; gi < `CE_LP_ORDER; gi++) begin : g_mem
            always_ff @(posedge mclk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    mem_syn[gi] <= 16'h0000;
                    lpc[gi] <= 16'h0000;
                end else begin
                    if (s_r.st == CE_S_UPD) begin
                        mem_syn[gi] <= (gi == 0) ? s_r.exc :
                                       mem_syn[(gi == 0) ? 0 : gi - 1];
                    end
                    if (s_r.st == CE_S_LP && s_r.cnt < 8'(`CE_SUB_LEN)) begin
                        lpc[gi] <= lpc[gi] + 16'((32'(frame_buf[s_r.cnt])
                                   * 32'(s_r.g1)) >> 15);
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.stb_sync = {s_r.stb_sync[1:0], smp_stb_i};
        s_nxt.smp_s1 = smp_i;
        s_nxt.smp_s2 = s_r.smp_s1;
        s_nxt.lin_vld = 1'b0;
        s_nxt.bit_vld = 1'b0;
        s_nxt.fs = 1'b0;
        s_nxt.fe = 1'b0;
        // every strobe sample taken, loss flagged
        if (stb_rise) begin
            s_nxt.lin_vld = 1'b1;
            case (fmt_i)
                CE_FMT_ALAW: s_nxt.lin = to_word(alaw_exp(s_r.smp_s2[7:0]));
                CE_FMT_ULAW: s_nxt.lin = to_word(ulaw_exp(s_r.smp_s2[7:0]));
                default: s_nxt.lin = to_word(s_r.smp_s2[15:`CE_LSB_PAD]);
            endcase
            if (!fifo_irdy) s_nxt.ovr = 1'b1;
        end
        case (s_r.st)
            CE_S_IDLE: begin
                // start once 160 samples are held
                if (frame_full) begin
                    s_nxt.fmode = mode_i;
                    s_nxt.g1 = (mode_i == CE_M122 || mode_i == CE_M102) ?
                               `CE_G1_HI : `CE_G1_LO;
                    s_nxt.lp_pass = (mode_i == CE_M122) ? 2'h2 : 2'h1;
                    s_nxt.fbits = frame_bits(mode_i);
                    s_nxt.sub = 8'h00;
                    s_nxt.cnt = 8'h00;
                    s_nxt.bitcnt = 8'h00;
                    s_nxt.fs = 1'b1;
                    s_nxt.st = CE_S_LP;
                end
            end
            CE_S_LP: begin
                s_nxt.cnt = s_r.cnt + 8'h01;
                if (s_r.cnt == 8'(`CE_SUB_LEN)) begin
                    s_nxt.cnt = 8'h00;
                    s_nxt.lp_pass = s_r.lp_pass - 2'h1;
                    // quantiser choice; sets feed the emitted word
                    if (s_r.lp_pass == 2'h1) begin
                        s_nxt.acc = s_r.acc ^ 32'(s_r.g1);
                        s_nxt.st = CE_S_OL;
                    end
                end
            end
            CE_S_OL: begin
                s_nxt.ol_lag = frame_buf[8'(s_r.sub * `CE_SUB_LEN)] ^
                               lpc[0] ^ `CE_G2;
                s_nxt.st = CE_S_SUB;
            end
            CE_S_SUB: begin
                s_nxt.cnt = s_r.cnt + 8'h01;
                s_nxt.acc = s_r.acc + 32'(frame_buf[8'(s_r.sub *
                            `CE_SUB_LEN) + s_r.cnt]) - 32'(mem_syn[0]);
                if (s_r.cnt == 8'(`CE_SUB_LEN - 1)) begin
                    // excitation from past lag, frac resolution
                    s_nxt.exc = s_r.acc[15:0] + s_r.ol_lag;
                    s_nxt.sh = s_r.acc[31:16];
                    s_nxt.shcnt = 4'hf;
                    s_nxt.cnt = 8'h00;
                    s_nxt.st = CE_S_EMIT;
                end
            end
            CE_S_EMIT: begin
                // msb first; exact bit total per frame
                s_nxt.bit_q = s_r.sh[15];
                s_nxt.bit_vld = 1'b1;
                s_nxt.sh = {s_r.sh[14:0], 1'b0};
                s_nxt.shcnt = s_r.shcnt - 4'h1;
                s_nxt.bitcnt = s_r.bitcnt + 8'h01;
                if (s_r.bitcnt + 8'h01 == s_r.fbits) begin
                    s_nxt.fe = 1'b1;
                    s_nxt.st = CE_S_UPD;
                end else if (s_r.shcnt == 4'h0) begin
                    s_nxt.st = CE_S_UPD;
                end
            end
            CE_S_UPD: begin
                // four subframes; excitation word joins stream
                s_nxt.dec = {s_r.exc[15:`CE_LSB_PAD], `CE_LSB_PAD'(0)};
                if (s_r.bitcnt == s_r.fbits) begin
                    s_nxt.st = CE_S_IDLE;
                end else if (s_r.sub != 8'(`CE_NUM_SUB - 1)) begin
                    s_nxt.sub = s_r.sub + 8'h01;
                    s_nxt.st = (s_r.sub[0] == 1'b1 &&
                                s_r.fmode != CE_M515 &&
                                s_r.fmode != CE_M475) ? CE_S_OL : CE_S_SUB;
                end else begin
                    s_nxt.sh = s_r.exc;
                    s_nxt.shcnt = 4'hf;
                    s_nxt.st = CE_S_EMIT;
                end
            end
            default: s_nxt.st = CE_S_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_r <= '0;
            s_r.st <= CE_S_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign bit_o = s_r.bit_q;
    assign bit_vld_o = s_r.bit_vld;
    assign frame_start_o = s_r.fs;
    assign frame_end_o = s_r.fe;
    assign frame_mode_o = s_r.fmode;
    assign sub_idx_o = s_r.sub;
    assign dec_smp_o = s_r.dec;
    assign overrun_o = s_r.ovr;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_pad_zero;
        @(posedge mclk_i) disable iff (!rstn_i)
        s_r.lin_vld |-> s_r.lin[2:0] == 3'h0;
    endproperty
    a_pad_zero: assert property (p_pad_zero)
        else $error("sample low bits not zero");
    property p_dec_fmt;
        @(posedge mclk_i) disable iff (!rstn_i)
        dec_smp_o[2:0] == 3'h0;
    endproperty
    a_dec_fmt: assert property (p_dec_fmt)
        else $error("decoded sample not left justified");
    property p_mode_hold;
        @(posedge mclk_i) disable iff (!rstn_i)
        (s_r.st != CE_S_IDLE) |=> $stable(s_r.fmode) || $past(s_r.fs);
    endproperty
    a_mode_hold: assert property (p_mode_hold)
        else $error("mode changed inside a frame");
    property p_g1;
        @(posedge mclk_i) disable iff (!rstn_i)
        s_r.fs |-> s_r.g1 == ((s_r.fmode == CE_M122 ||
            s_r.fmode == CE_M102) ? `CE_G1_HI : `CE_G1_LO);
    endproperty
    a_g1: assert property (p_g1)
        else $error("weighting factor wrong for mode");
    property p_lp_pass;
        @(posedge mclk_i) disable iff (!rstn_i)
        s_r.fs |-> s_r.lp_pass == ((s_r.fmode == CE_M122) ? 2'h2 : 2'h1);
    endproperty
    a_lp_pass: assert property (p_lp_pass)
        else $error("lp pass count wrong");
    property p_bits;
        @(posedge mclk_i) disable iff (!rstn_i)
        s_r.fe |-> s_r.bitcnt == frame_bits(s_r.fmode);
    endproperty
    a_bits: assert property (p_bits)
        else $error("frame bit total wrong");
    property p_sub_max;
        @(posedge mclk_i) disable iff (!rstn_i)
        s_r.sub < 8'(`CE_NUM_SUB);
    endproperty
    a_sub_max: assert property (p_sub_max)
        else $error("subframe index out of range");
    property p_msb;
        @(posedge mclk_i) disable iff (!rstn_i)
        (s_r.st == CE_S_EMIT) |=> s_r.bit_q == $past(s_r.sh[15]);
    endproperty
    a_msb: assert property (p_msb)
        else $error("bit not msb first");
endmodule : celp_encoder
`default_nettype wire

// [hw/celp_defines.svh]
// constants of the speech frame encoder
`ifndef CELP_DEFINES_SVH
`define CELP_DEFINES_SVH
`define CE_CLK_HZ 20000000
`define CE_FS_HZ 8000
`define CE_SMP_DIV (`CE_CLK_HZ / `CE_FS_HZ)
`define CE_FRAME_MS 20
`define CE_FRAME_LEN 160
`define CE_SUB_LEN 40
`define CE_NUM_SUB 4
`define CE_LP_ORDER 10
`define CE_LSB_PAD 3
`define CE_LIN_BITS 13
`define CE_G1_HI 16'h7333
`define CE_G1_LO 16'h7852
`define CE_G2 16'h4ccd
`define CE_SMQ_BITS 38
`define CE_GAIN_SCALAR_P 4
`define CE_GAIN_SCALAR_C 5
`define CE_MU_BIAS 14'h0084
`define CE_A_SEG1 13'h0108
`endif

// [hw/celp_pkg.sv]
// types of the speech frame encoder
package celp_pkg;
    typedef enum logic [2:0] {
        CE_M475 = 3'h0, CE_M515 = 3'h1, CE_M590 = 3'h2, CE_M670 = 3'h3,
        CE_M740 = 3'h4, CE_M795 = 3'h5, CE_M102 = 3'h6, CE_M122 = 3'h7
    } celp_mode_e;
    typedef enum logic [1:0] {
        CE_FMT_LIN = 2'h0, CE_FMT_ALAW = 2'h1, CE_FMT_ULAW = 2'h2
    } celp_fmt_e;
    typedef enum logic [5:0] {
        CE_S_IDLE = 6'h01, CE_S_LP = 6'h02, CE_S_OL = 6'h04,
        CE_S_SUB = 6'h08, CE_S_EMIT = 6'h10, CE_S_UPD = 6'h20
    } celp_state_e;
endpackage : celp_pkg

// [hw/celp_fifo.sv]
// sample fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module celp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } celp_fifo_s;
    celp_fifo_s st_r, st_nxt;
    logic wr, rd;
    assign in_ready_o = (st_r.cnt != (AW+1)'(DEPTH));
    assign out_valid_o = (st_r.cnt != '0);
    assign out_data_o = mem[st_r.rp];
    assign wr = in_valid_i & in_ready_o;
    assign rd = out_valid_o & out_ready_i;
    always_comb begin
        st_nxt = st_r;
        if (wr) st_nxt.wp = st_r.wp + 1'b1;
        if (rd) st_nxt.rp = st_r.rp + 1'b1;
        st_nxt.cnt = st_r.cnt + (AW+1)'(wr) - (AW+1)'(rd);
    end
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) st_r <= '0;
        else st_r <= st_nxt;
    end
    always_ff @(posedge mclk_i) begin
        if (wr) mem[st_r.wp] <= in_data_i;
    end
endmodule : celp_fifo
`default_nettype wire

// [test/celp_audio_src.sv]
// audio sample source model feeding the speech frame encoder
`timescale 1ns/1ps
`default_nettype none
module celp_audio_src #(
    parameter int GAP = 8
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic [1:0] fmt_i,
    output logic smp_stb_o,
    output logic [15:0] smp_o
);
    // ------------------------------------------------------------
    // sample pacing and word
    // ------------------------------------------------------------
    int cnt;
    logic [12:0] lin;

    always @(negedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt <= 0;
            lin <= 13'h1000;
            smp_stb_o <= 1'b0;
            smp_o <= 16'h0000;
        end else begin
            cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
            smp_stb_o <= (cnt < 2);
            if (cnt == 0) begin
                lin <= lin + 13'h0155;
                if (fmt_i == 2'h0) begin
                    smp_o <= {lin, 3'h0};
                end else begin
                    smp_o <= {8'h00, lin[7:0]};
                end
            end else if (cnt == 4) begin
                // word no longer held once taken: show a changing pattern
                smp_o <= ~smp_o;
            end
        end
    end
endmodule : celp_audio_src
`default_nettype wire

// [test/tb_celp_encoder.sv]
// self-checking testbench of the speech frame encoder
`timescale 1ns/1ps
`default_nettype none
module tb_celp_encoder;
    import celp_pkg::*;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    logic mclk;
    logic rstn;
    logic smp_stb;
    logic [15:0] smp;
    logic bit_v;
    logic bit_vld;
    logic fstart;
    logic fend;
    logic [2:0] fmode;
    logic [7:0] sub_idx;
    logic [15:0] dec_smp;
    logic overrun;
    celp_fmt_e fmt;
    celp_mode_e mode;
    int mismatches;
    int tests_run;
    int frame_bits [8] = '{95, 103, 118, 134, 148, 159, 204, 244};

    initial mclk = 1'b0;
    always #25 mclk = ~mclk;

    celp_encoder #(.FIFO_DEPTH(16)) u_celp_encoder (
        .mclk_i(mclk),
        .rstn_i(rstn),
        .smp_stb_i(smp_stb),
        .smp_i(smp),
        .fmt_i(fmt),
        .mode_i(mode),
        .bit_o(bit_v),
        .bit_vld_o(bit_vld),
        .frame_start_o(fstart),
        .frame_end_o(fend),
        .frame_mode_o(fmode),
        .sub_idx_o(sub_idx),
        .dec_smp_o(dec_smp),
        .overrun_o(overrun)
    );

    celp_audio_src #(.GAP(8)) u_celp_audio_src (
        .mclk_i(mclk),
        .rstn_i(rstn),
        .fmt_i(fmt),
        .smp_stb_o(smp_stb),
        .smp_o(smp)
    );

    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test;
        if (mismatches == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic timeout_hit;
        check(32'h0, 32'h1);
        finish_test();
    endtask : timeout_hit

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // outputs quiet right after reset release
    task automatic reset_values;
        @(negedge mclk);
        check({31'h0, bit_vld}, 32'h0);
        check({31'h0, fstart}, 32'h0);
        check({31'h0, fend}, 32'h0);
        check({31'h0, overrun}, 32'h0);
        check({16'h0, dec_smp}, 32'h0);
    endtask : reset_values

    // one frame in mode m; next mode and format are set mid-frame
    task automatic run_frame(input int m);
        int n;
        int bits;
        n = 0;
        bits = 0;
        while (fstart !== 1'b1 && n < 5000) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 5000) begin
            timeout_hit();
        end
        mode = celp_mode_e'((m + 1) % 8);
        fmt = celp_fmt_e'((m + 1) % 3);
        n = 0;
        do begin
            @(negedge mclk);
            n++;
            if (bit_vld === 1'b1) begin
                bits++;
                check({31'h0, sub_idx <= 8'h03}, 32'h1);
                check({31'h0, bit_v === 1'b0 || bit_v === 1'b1}, 32'h1);
            end
        end while (fend !== 1'b1 && n < 5000);
        if (n >= 5000) begin
            timeout_hit();
        end
        check({31'h0, bit_vld}, 32'h1);
        check(bits, frame_bits[m]);
        check({29'h0, fmode}, m);
        check({29'h0, dec_smp[2:0]}, 32'h0);
    endtask : run_frame

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        mismatches = 0;
        tests_run = 0;
        rstn = 1'b0;
        fmt = CE_FMT_LIN;
        mode = CE_M475;
        repeat (5) @(negedge mclk);
        rstn = 1'b1;
        reset_values();
        for (int m = 0; m < 8; m++) begin
            run_frame(m);
        end
        check({31'h0, overrun}, 32'h0);
        finish_test();
    end
endmodule : tb_celp_encoder
`default_nettype wire
